// ---- rtl/scr_synth_ctrl.sv ----
// Purpose: Register bank and sequencing of a triple-PLL synthesizer
// Assumes: Serial clock, enable, data, reference and pins are asynchronous to CLK
// Notes:   Serial clock must be well below CLK/4 so its edges are seen
`default_nettype none

// Function
// - Reference divided by fixed 65 for all three PLLs.
// - Writing either RF divider selects that RF oscillator for the RF output.
// - RF1, RF2, IF divide ratios live at addresses 3, 4, 5.
// - Prescaler, swallow and counter values derive from the divide ratio alone.
// - First 6.5 update periods after powerup or ratio change are self-tuning.
// - Output settles about 21 update periods after the PLL takes control.
// - Total time to settled is about 28 update periods.
// - IF low-power bit set reduces IF amplifier bias; clear gives normal bias.
// - Powerdown pin low forces IF and RF off whatever the registers hold.
// - Pin high: sections follow powerdown bits and automatic power-up bit.
// - Pin high, auto clear: IF on with IF enable, RF on with RF enable.
// - Reference amplifier powered when pin is high and both section enables are high.
// - Automatic power-up acts as both enable bits set.
// - Serial writes are accepted in every powerdown state.
// - Auxiliary select 11 puts the lock-warning signal on the aux pin.
// - Lock warning is the OR of IF and RF warning conditions.
// - Auxiliary select 01 drives the aux pin low; 00 and 10 reserved.
// - Lock warning is also high while either PLL self-tunes.
// - Words are 22 bits: 18 data, 4 address, shifted on rising clock.
// - Rising enable copies the data field into the addressed register.
module scr_synth_ctrl
    import scr_pkg::*;
#(
    parameter int PRESCALE_LOG2 = scr_pkg::SCR_PRESCALE_LOG2
) (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     SYS_RST,
    // Serial programming link
    input  wire logic                     SERIAL_CLOCK,
    input  wire logic                     SERIAL_ENABLE_N,
    input  wire logic                     SERIAL_DATA_IN,
    // Pins and analog conditions
    input  wire logic                     POWER_DOWN_PIN_N,
    input  wire logic                     REFERENCE_INPUT,
    input  wire logic                     IF_NEAR_LIMIT,
    input  wire logic                     RF_NEAR_LIMIT,
    // Section control
    output var  scr_pkg::scr_sec_status_s IF_STATUS,
    output var  scr_pkg::scr_sec_status_s RF_STATUS,
    output var  logic                     REF_AMP_ON,
    output var  logic                     RF2_SELECTED,
    output var  logic                     IF_LOW_POWER,
    output var  logic                     UPDATE_TICK,
    // Divider settings for the active RF PLL and the IF PLL
    output var  scr_pkg::scr_div_cfg_s    RF_DIV_CFG,
    output var  scr_pkg::scr_div_cfg_s    IF_DIV_CFG,
    // Auxiliary output
    output var  logic                     LOCK_WARNING_N,
    output var  logic                     AUX_OUTPUT_PIN
);
    import scr_pkg::*;

    localparam logic [6:0] EDGE_LAST = 7'(SCR_EDGES_PER_HALF - 1);
    localparam logic [5:0] TUNE_END  = 6'(SCR_TUNE_HALVES);
    localparam logic [5:0] TOTAL_END = 6'(SCR_TOTAL_HALVES);

    // Input synchronisers: stage one feeds stage two only
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic       sclk_prev_q;
    logic       sen_prev_q;
    logic       ref_prev_q;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sync1_q <= 7'h28;
            sync2_q <= 7'h28;
        end else begin
            sync1_q <= {SERIAL_CLOCK, SERIAL_ENABLE_N, SERIAL_DATA_IN, POWER_DOWN_PIN_N,
                        REFERENCE_INPUT, IF_NEAR_LIMIT, RF_NEAR_LIMIT};
            sync2_q <= sync1_q;
        end
    end

    logic sclk_s;
    logic sen_n_s;
    logic serial_data_in_s;
    logic pin_n_s;
    logic ref_s;
    logic if_near_s;
    logic rf_near_s;

    assign {sclk_s, sen_n_s, serial_data_in_s, pin_n_s, ref_s, if_near_s, rf_near_s} = sync2_q;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sclk_prev_q <= 1'b1;
            sen_prev_q  <= 1'b1;
            ref_prev_q  <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            sen_prev_q  <= sen_n_s;
            ref_prev_q  <= ref_s;
        end
    end

    logic sclk_rise;
    logic sen_rise;
    logic ref_edge;

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sen_rise  = sen_n_s & ~sen_prev_q;
    assign ref_edge  = ref_s ^ ref_prev_q;

    // Serial shift register, last 22 bits kept; earlier bits fall off the top
    logic [SCR_WORD_BITS-1:0] shift_q;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            shift_q <= '0;
        end else if (sclk_rise && !sen_n_s) begin
            shift_q <= {shift_q[SCR_WORD_BITS-2:0], serial_data_in_s};
        end
    end

    logic [SCR_DATA_BITS-1:0] wr_data;
    logic [SCR_ADDR_BITS-1:0] wr_addr;
    logic                     wr_main;
    logic                     wr_power;
    logic                     wr_rf1;
    logic                     wr_rf2;
    logic                     wr_if;

    assign wr_data  = shift_q[SCR_WORD_BITS-1:SCR_ADDR_BITS];
    assign wr_addr  = shift_q[SCR_ADDR_BITS-1:0];
    // Writes are taken regardless of any powerdown state
    assign wr_main  = sen_rise && (wr_addr == SCR_ADDR_MAIN);
    assign wr_power = sen_rise && (wr_addr == SCR_ADDR_POWER);
    assign wr_rf1   = sen_rise && (wr_addr == SCR_ADDR_RF1);
    assign wr_rf2   = sen_rise && (wr_addr == SCR_ADDR_RF2);
    assign wr_if    = sen_rise && (wr_addr == SCR_ADDR_IF);

    // Registers; other addresses are simply ignored
    logic [17:0]             main_configuration_q;
    logic [17:0]             section_power_control_q;
    logic [SCR_RF1_BITS-1:0] rf1_divide_ratio_q;
    logic [SCR_RF2_BITS-1:0] rf2_divide_ratio_q;
    logic [SCR_IF_BITS-1:0]  if_divide_ratio_q;
    logic                    rf2_sel_q;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            main_configuration_q    <= SCR_RST_MAIN;
            section_power_control_q <= SCR_RST_POWER;
        end else begin
            if (wr_main) begin
                main_configuration_q <= wr_data;
            end
            if (wr_power) begin
                section_power_control_q <= wr_data;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rf1_divide_ratio_q <= SCR_RST_DIV[SCR_RF1_BITS-1:0];
            rf2_divide_ratio_q <= SCR_RST_DIV[SCR_RF2_BITS-1:0];
            if_divide_ratio_q  <= SCR_RST_DIV[SCR_IF_BITS-1:0];
        end else begin
            if (wr_rf1) begin
                rf1_divide_ratio_q <= wr_data[SCR_RF1_BITS-1:0];
            end
            if (wr_rf2) begin
                rf2_divide_ratio_q <= wr_data[SCR_RF2_BITS-1:0];
            end
            if (wr_if) begin
                if_divide_ratio_q <= wr_data[SCR_IF_BITS-1:0];
            end
        end
    end

    // Last RF divider written owns the RF output
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rf2_sel_q <= 1'b0;
        end else if (wr_rf1) begin
            rf2_sel_q <= 1'b0;
        end else if (wr_rf2) begin
            rf2_sel_q <= 1'b1;
        end
    end

    // Section power decode
    logic auto_up;
    logic if_en;
    logic rf_en;
    logic [1:0] sec_on;
    logic [1:0] sec_on_q;
    logic [1:0] restart;

    assign auto_up = main_configuration_q[SCR_AUTO_UP_BIT];
    assign if_en   = section_power_control_q[SCR_IF_EN_BIT] | auto_up;
    assign rf_en   = section_power_control_q[SCR_RF_EN_BIT] | auto_up;
    // Pin low overrides all; pin high follows the enables
    assign sec_on  = {pin_n_s & if_en, pin_n_s & rf_en};

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sec_on_q <= 2'b00;
        end else begin
            sec_on_q <= sec_on;
        end
    end

    // Tuning restarts on a divide write or a fresh power-up
    assign restart = {wr_if | (sec_on[1] & ~sec_on_q[1]),
                      wr_rf1 | wr_rf2 | (sec_on[0] & ~sec_on_q[0])};

    // Reference divide: both reference edges counted, 65 edges make half an update period
    logic [6:0] edge_cnt_q;
    logic       half_tick;
    logic       phase_q;

    assign half_tick = ref_edge && (edge_cnt_q == EDGE_LAST);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            edge_cnt_q <= '0;
            phase_q    <= 1'b0;
        end else if (ref_edge) begin
            edge_cnt_q <= half_tick ? 7'h00 : edge_cnt_q + 7'h01;
            if (half_tick) begin
                phase_q <= ~phase_q;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            UPDATE_TICK <= 1'b0;
        end else begin
            UPDATE_TICK <= half_tick & phase_q;
        end
    end

    // Per-section self-tune and settle sequencer; index 1 is IF, 0 is RF
    scr_sec_status_s sec_status [2];

    for (genvar s = 0; s < 2; s++) begin : g_sec
        scr_sec_e   state_q;
        logic [5:0] halves_q;

        always_ff @(posedge CLK) begin
            if (SYS_RST) begin
                state_q  <= SCR_SEC_OFF;
                halves_q <= '0;
            end else if (!sec_on[s]) begin
                state_q  <= SCR_SEC_OFF;
                halves_q <= '0;
            end else if (restart[s]) begin
                state_q  <= SCR_SEC_TUNE;
                halves_q <= '0;
            end else if (half_tick) begin
                case (state_q)
                    SCR_SEC_TUNE: begin
                        halves_q <= halves_q + 6'h01;
                        if (halves_q + 6'h01 == TUNE_END) begin
                            state_q <= SCR_SEC_LOCKING;
                        end
                    end
                    SCR_SEC_LOCKING: begin
                        halves_q <= halves_q + 6'h01;
                        if (halves_q + 6'h01 == TOTAL_END) begin
                            state_q <= SCR_SEC_SETTLED;
                        end
                    end
                    SCR_SEC_SETTLED: begin
                        halves_q <= halves_q;
                    end
                    default: begin
                        state_q <= SCR_SEC_TUNE;
                    end
                endcase
            end
        end

        always_ff @(posedge CLK) begin
            if (SYS_RST) begin
                sec_status[s] <= '0;
            end else begin
                sec_status[s].on      <= state_q != SCR_SEC_OFF;
                sec_status[s].tuning  <= state_q == SCR_SEC_TUNE;
                sec_status[s].locking <= state_q == SCR_SEC_LOCKING;
                sec_status[s].settled <= state_q == SCR_SEC_SETTLED;
            end
        end
    end

    assign IF_STATUS = sec_status[1];
    assign RF_STATUS = sec_status[0];

    // Control outputs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            REF_AMP_ON   <= 1'b0;
            RF2_SELECTED <= 1'b0;
            IF_LOW_POWER <= 1'b0;
        end else begin
            REF_AMP_ON   <= pin_n_s & if_en & rf_en;
            RF2_SELECTED <= rf2_sel_q;
            IF_LOW_POWER <= main_configuration_q[SCR_LOW_POWER_BIT];
        end
    end

    // Divider split into P/P+1 prescaler swallow count and main counter
    function automatic scr_div_cfg_s split_ratio(input logic [17:0] n);
        scr_div_cfg_s c;
        c.ratio   = n;
        c.swallow = n & ((18'h00001 << PRESCALE_LOG2) - 18'h00001);
        c.counter = n >> PRESCALE_LOG2;
        return c;
    endfunction

    logic [17:0] rf_ratio;

    assign rf_ratio = rf2_sel_q ? {1'b0, rf2_divide_ratio_q} : rf1_divide_ratio_q;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RF_DIV_CFG <= '0;
            IF_DIV_CFG <= '0;
        end else begin
            RF_DIV_CFG <= split_ratio(rf_ratio);
            IF_DIV_CFG <= split_ratio({2'b00, if_divide_ratio_q});
        end
    end

    // Lock warning and auxiliary output
    logic       warn;
    logic [1:0] aux_sel;

    assign warn    = (sec_on[1] & (if_near_s | sec_status[1].tuning)) |
                     (sec_on[0] & (rf_near_s | sec_status[0].tuning));
    assign aux_sel = main_configuration_q[SCR_AUX_SEL_LSB+1:SCR_AUX_SEL_LSB];

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            LOCK_WARNING_N <= 1'b0;
            AUX_OUTPUT_PIN <= 1'b0;
        end else begin
            LOCK_WARNING_N <= warn;
            case (aux_sel)
                SCR_AUX_LOCK_WARN: AUX_OUTPUT_PIN <= warn;
                SCR_AUX_FORCE_LOW: AUX_OUTPUT_PIN <= 1'b0;
                default:           AUX_OUTPUT_PIN <= 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- pkg/scr_pkg.sv ----
// Purpose: Shared constants and types of the synthesizer control registers
// Assumes: 22-bit serial words, data bits first, address bits last
// Notes:   Update-period timing is counted in half update periods
`default_nettype none
package scr_pkg;
    // Serial word layout
    localparam int SCR_WORD_BITS = 22;
    localparam int SCR_DATA_BITS = 18;
    localparam int SCR_ADDR_BITS = 4;

    // Register addresses
    localparam logic [3:0] SCR_ADDR_MAIN  = 4'h0;
    localparam logic [3:0] SCR_ADDR_POWER = 4'h2;
    localparam logic [3:0] SCR_ADDR_RF1   = 4'h3;
    localparam logic [3:0] SCR_ADDR_RF2   = 4'h4;
    localparam logic [3:0] SCR_ADDR_IF    = 4'h5;

    // Field positions
    localparam int SCR_AUX_SEL_LSB  = 12;
    localparam int SCR_LOW_POWER_BIT = 5;
    localparam int SCR_AUTO_UP_BIT  = 3;
    localparam int SCR_IF_EN_BIT    = 1;
    localparam int SCR_RF_EN_BIT    = 0;

    // Divide ratio widths
    localparam int SCR_RF1_BITS = 18;
    localparam int SCR_RF2_BITS = 17;
    localparam int SCR_IF_BITS  = 16;

    // Auxiliary output select codes
    localparam logic [1:0] SCR_AUX_FORCE_LOW = 2'h1;
    localparam logic [1:0] SCR_AUX_LOCK_WARN = 2'h3;

    // Reset values
    localparam logic [17:0] SCR_RST_MAIN  = 18'h00000;
    localparam logic [17:0] SCR_RST_POWER = 18'h00000;
    localparam logic [17:0] SCR_RST_DIV   = 18'h00000;

    // Reference divider and update-period timing
    localparam int SCR_REF_DIVIDE       = 65;
    localparam int SCR_EDGES_PER_HALF   = SCR_REF_DIVIDE;
    localparam int SCR_TUNE_PERIODS_X10 = 65;
    localparam int SCR_SETTLE_PERIODS   = 21;
    localparam int SCR_TOTAL_PERIODS    = 28;
    localparam int SCR_TUNE_HALVES      = SCR_TUNE_PERIODS_X10 * 2 / 10;
    localparam int SCR_SETTLE_HALVES    = SCR_SETTLE_PERIODS * 2;
    localparam int SCR_TOTAL_HALVES     = SCR_TOTAL_PERIODS * 2;

    // Divider-derived prescaler default (log2 of P in a P/P+1 prescaler)
    localparam int SCR_PRESCALE_LOG2 = 5;

    typedef enum {
        SCR_SEC_OFF,
        SCR_SEC_TUNE,
        SCR_SEC_LOCKING,
        SCR_SEC_SETTLED
    } scr_sec_e;

    typedef struct packed {
        logic on;
        logic tuning;
        logic locking;
        logic settled;
    } scr_sec_status_s;

    typedef struct packed {
        logic [17:0] ratio;
        logic [17:0] swallow;
        logic [17:0] counter;
    } scr_div_cfg_s;
endpackage
`default_nettype wire

// ---- bench/scr_synth_ctrl_checker.sv ----
// Purpose: Port assertions for the synthesizer control registers
// Assumes: Pin and serial inputs pass a two-stage synchroniser
// Notes:   Tick counts allow for the free-running half-period phase
`default_nettype none
module scr_synth_ctrl_checker
    import scr_pkg::*;
#(
    parameter int PRESCALE_LOG2 = 5
) (
    // Clock and reset
    input wire logic                     CLK,
    input wire logic                     SYS_RST,
    // Inputs watched
    input wire logic                     POWER_DOWN_PIN_N,
    input wire logic                     IF_NEAR_LIMIT,
    input wire logic                     RF_NEAR_LIMIT,
    // Outputs watched
    input wire scr_pkg::scr_sec_status_s IF_STATUS,
    input wire scr_pkg::scr_sec_status_s RF_STATUS,
    input wire logic                     REF_AMP_ON,
    input wire logic                     UPDATE_TICK,
    input wire scr_pkg::scr_div_cfg_s    RF_DIV_CFG,
    input wire logic                     LOCK_WARNING_N,
    input wire logic                     AUX_OUTPUT_PIN
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       rf_tun_q;
    logic [7:0] rf_ticks_q;
    logic [2:0] near_age_q;

    // Update periods since the RF section last began tuning
    always_ff @(posedge CLK) begin
        rf_tun_q <= RF_STATUS.tuning;
        if (SYS_RST || (RF_STATUS.tuning && !rf_tun_q)) begin
            rf_ticks_q <= 8'h00;
        end else if (UPDATE_TICK) begin
            rf_ticks_q <= rf_ticks_q + 8'h01;
        end
    end

    // Cycles since a near-limit input was last high, saturating
    always_ff @(posedge CLK) begin
        if (IF_NEAR_LIMIT || RF_NEAR_LIMIT) begin
            near_age_q <= 3'h0;
        end else if (SYS_RST || near_age_q != 3'h7) begin
            near_age_q <= SYS_RST ? 3'h7 : near_age_q + 3'h1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_pin_held;
        !POWER_DOWN_PIN_N [*5];
    endsequence
    sequence s_tune_done;
        $fell(RF_STATUS.tuning) ##0 RF_STATUS.locking;
    endsequence

    property p_reset_clear;
        $past(SYS_RST) |-> IF_STATUS == 4'h0 && RF_STATUS == 4'h0 && !REF_AMP_ON;
    endproperty
    property p_pin_off;
        s_pin_held |-> !IF_STATUS.on && !RF_STATUS.on && !REF_AMP_ON;
    endproperty
    property p_off_idle;
        !IF_STATUS.on |-> !IF_STATUS.tuning && !IF_STATUS.locking && !IF_STATUS.settled;
    endproperty
    property p_tick_pulse;
        UPDATE_TICK |=> !UPDATE_TICK [*8];
    endproperty
    property p_tune_len;
        s_tune_done |-> rf_ticks_q inside {[8'h06:8'h07]};
    endproperty
    property p_settle_order;
        $rose(RF_STATUS.settled) |-> $past(RF_STATUS.locking);
    endproperty
    property p_total_len;
        $rose(RF_STATUS.settled) |-> rf_ticks_q inside {[8'h1b:8'h1c]};
    endproperty
    property p_tune_warn;
        RF_STATUS.tuning [*3] |-> $past(LOCK_WARNING_N);
    endproperty
    property p_warn_cause;
        LOCK_WARNING_N |-> near_age_q < 3'h6 || IF_STATUS.tuning || RF_STATUS.tuning
            || $past(IF_STATUS.tuning) || $past(RF_STATUS.tuning);
    endproperty
    property p_aux_warn;
        AUX_OUTPUT_PIN |-> LOCK_WARNING_N || $past(LOCK_WARNING_N);
    endproperty
    property p_div_split;
        RF_DIV_CFG.counter == RF_DIV_CFG.ratio >> PRESCALE_LOG2 && RF_DIV_CFG.swallow
            == (RF_DIV_CFG.ratio & ((18'h1 << PRESCALE_LOG2) - 18'h1));
    endproperty

    a_reset_clear: assert property (p_reset_clear) else $error("state kept over reset");
    a_pin_off: assert property (p_pin_off) else $error("section on with pin low");
    a_off_idle: assert property (p_off_idle) else $error("idle section not clear");
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
    a_tune_len: assert property (p_tune_len) else $error("tuning span wrong");
    a_settle_order: assert property (p_settle_order) else $error("settled early");
    a_total_len: assert property (p_total_len) else $error("settle span wrong");
    a_tune_warn: assert property (p_tune_warn) else $error("no warning in tuning");
    a_warn_cause: assert property (p_warn_cause) else $error("warning without cause");
    a_aux_warn: assert property (p_aux_warn) else $error("aux high without warning");
    a_div_split: assert property (p_div_split) else $error("divider split wrong");
endmodule
`default_nettype wire

// ---- bench/scr_host_model.sv ----
// Purpose: Host side of the three-wire programming link
// Assumes: Serial clock period of 125 ns, idle low between words
// Notes:   Data line is inverted when released so stale bits never pass
`default_nettype none
module scr_host_model (
    // Serial link toward the device
    output var logic SERIAL_CLOCK,
    output var logic SERIAL_ENABLE_N,
    output var logic SERIAL_DATA_IN
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam realtime HALF = 62.5;

    initial begin
        SERIAL_CLOCK = 1'b0;
        SERIAL_ENABLE_N = 1'b1;
        SERIAL_DATA_IN = 1'b0;
    end

    // Callers pass only documented addresses
    task automatic send(input logic [3:0] addr, input logic [17:0] data);
        logic [21:0] word;
        word = {data, addr};
        SERIAL_ENABLE_N = 1'b0;
        for (int i = 21; i >= 0; i--) begin
            SERIAL_DATA_IN = word[i];
            #(HALF) SERIAL_CLOCK = 1'b1;
            #(HALF) SERIAL_CLOCK = 1'b0;
        end
        #(HALF) SERIAL_ENABLE_N = 1'b1;
        SERIAL_DATA_IN = ~SERIAL_DATA_IN;
        #(2 * HALF);
    endtask
endmodule
`default_nettype wire

// ---- bench/scr_synth_ctrl_test.sv ----
// Purpose: Self-checking bench for the synthesizer control registers
// Assumes: Reference toggles every 4 CLK, so an update period is 520 CLK
// Notes:   Reset check runs first, then power rows, dividers, pin, timing and reset again
`default_nettype none
module scr_synth_ctrl_test
    import scr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic            clk;
    logic            sys_rst;
    logic            pin_n;
    logic            if_near;
    logic            rf_near;
    logic [2:0]      ref_cnt = 3'h0;
    wire logic       sclk;
    wire logic       sen_n;
    wire logic       serial_data_in;
    scr_sec_status_s if_st;
    scr_sec_status_s rf_st;
    logic            amp;
    logic            rf2_sel;
    logic            low_pwr;
    logic            tick;
    logic            warn;
    logic            aux;
    scr_div_cfg_s    rf_cfg;
    scr_div_cfg_s    if_cfg;
    logic            tun_prev;
    int              ticks;
    int              n_fail;
    int              n_tests;
    // Row: pin, auto, if en, rf en, low power | if on, rf on, ref amp
    localparam logic [7:0] rows [8] = '{8'h70, 8'h88, 8'h92, 8'hac, 8'hb7, 8'hcf, 8'h30, 8'he7};

    scr_host_model i_host (
        .SERIAL_CLOCK    (sclk),
        .SERIAL_ENABLE_N (sen_n),
        .SERIAL_DATA_IN  (serial_data_in)
    );

    scr_synth_ctrl i_dut (
        .CLK(clk), .SYS_RST(sys_rst), .SERIAL_CLOCK(sclk), .SERIAL_ENABLE_N(sen_n),
        .SERIAL_DATA_IN(serial_data_in), .POWER_DOWN_PIN_N(pin_n), .REFERENCE_INPUT(ref_cnt[2]),
        .IF_NEAR_LIMIT(if_near), .RF_NEAR_LIMIT(rf_near), .IF_STATUS(if_st), .RF_STATUS(rf_st),
        .REF_AMP_ON(amp), .RF2_SELECTED(rf2_sel), .IF_LOW_POWER(low_pwr), .UPDATE_TICK(tick),
        .RF_DIV_CFG(rf_cfg), .IF_DIV_CFG(if_cfg), .LOCK_WARNING_N(warn), .AUX_OUTPUT_PIN(aux)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Reference source and update periods since IF tuning began
    always @(posedge clk) begin
        ref_cnt <= ref_cnt + 3'h1;
        tun_prev <= if_st.tuning;
        if (if_st.tuning && !tun_prev) ticks <= 0;
        else if (tick) ticks <= ticks + 1;
    end

    task automatic check(input logic [53:0] seen, input logic [53:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [17:0] d);
        @(negedge clk);
        i_host.send(a, d);
        cycles(8);
    endtask

    function automatic logic [53:0] cfg(input logic [17:0] n);
        return {n, n & 18'h0001f, n >> 5};
    endfunction

    task automatic check_zero;
        @(negedge clk);
        check({if_st, rf_st, amp, rf2_sel, low_pwr, warn, aux}, 54'h0);
        check(rf_cfg, 54'h0);
    endtask

    task automatic near_step(input logic [1:0] lim, input logic [1:0] exp);
        @(posedge clk);
        {if_near, rf_near} <= lim;
        cycles(6);
        @(negedge clk);
        check({warn, aux}, exp);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        sys_rst = 1'b1;
        pin_n = 1'b1;
        if_near = 1'b0;
        rf_near = 1'b0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        cycles(4);
        check_zero;
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge clk);
            pin_n <= rows[i][7];
            wr(SCR_ADDR_MAIN, {6'h01, 6'h00, rows[i][3], 1'b0, rows[i][6], 3'h2});
            wr(SCR_ADDR_POWER, {16'h0, rows[i][5], rows[i][4]});
            @(negedge clk);
            check(if_st.on, rows[i][2]);
            check(rf_st.on, rows[i][1]);
            check(amp, rows[i][0]);
            check(low_pwr, rows[i][3]);
            check(aux, 1'b0);
            $display("test power row %0d done", i);
        end
        wr(SCR_ADDR_RF1, 18'h2d4c7);
        @(negedge clk);
        check(rf2_sel, 1'b0);
        check(rf_cfg, cfg(18'h2d4c7));
        wr(SCR_ADDR_RF2, 18'h1abcd);
        wr(SCR_ADDR_IF, 18'h0beef);
        @(negedge clk);
        check(rf2_sel, 1'b1);
        check(rf_cfg, cfg(18'h1abcd));
        check(if_cfg, cfg(18'h0beef));
        wr(SCR_ADDR_RF1, 18'h00145);
        @(negedge clk);
        check(rf2_sel, 1'b0);
        check(rf_cfg, cfg(18'h00145));
        $display("test dividers done");
        @(posedge clk);
        pin_n <= 1'b0;
        wr(SCR_ADDR_RF2, 18'h00321);
        @(negedge clk);
        check({if_st.on, rf_st.on, amp}, 3'h0);
        check(rf2_sel, 1'b1);
        check(rf_cfg, cfg(18'h00321));
        $display("test pin powerdown done");
        wr(SCR_ADDR_MAIN, 18'h03002);
        wr(SCR_ADDR_POWER, 18'h00003);
        wr(SCR_ADDR_IF, 18'h01234);
        @(posedge clk);
        pin_n <= 1'b1;
        cycles(8);
        @(negedge clk);
        check({warn, aux, if_st.tuning}, 3'h7);
        check(if_cfg, cfg(18'h01234));
        for (int i = 0; i < 8000 && if_st.tuning; i++) @(negedge clk);
        check(ticks inside {6, 7}, 1'b1);
        for (int i = 0; i < 20000 && !if_st.settled; i++) @(negedge clk);
        check(ticks inside {27, 28}, 1'b1);
        check(if_st, 4'h9);
        for (int i = 0; i < 20000 && !rf_st.settled; i++) @(negedge clk);
        check(rf_st, 4'h9);
        near_step(2'h0, 2'h0);
        near_step(2'h2, 2'h3);
        near_step(2'h1, 2'h3);
        near_step(2'h0, 2'h0);
        $display("test timing and warning done");
        @(posedge clk);
        sys_rst <= 1'b1;
        cycles(3);
        sys_rst <= 1'b0;
        cycles(2);
        check_zero;
        $display("test second reset done");
        tally_and_finish;
    end
endmodule

bind scr_synth_ctrl scr_synth_ctrl_checker #(.PRESCALE_LOG2(PRESCALE_LOG2)) i_chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .POWER_DOWN_PIN_N(POWER_DOWN_PIN_N),
    .IF_NEAR_LIMIT(IF_NEAR_LIMIT), .RF_NEAR_LIMIT(RF_NEAR_LIMIT), .IF_STATUS(IF_STATUS),
    .RF_STATUS(RF_STATUS), .REF_AMP_ON(REF_AMP_ON), .UPDATE_TICK(UPDATE_TICK),
    .RF_DIV_CFG(RF_DIV_CFG), .LOCK_WARNING_N(LOCK_WARNING_N), .AUX_OUTPUT_PIN(AUX_OUTPUT_PIN)
);
`default_nettype wire
